//--- bwc_pkg.sv
package bwc_pkg;

   // ****************************************
   // Widths and sizes
   // ****************************************
   localparam int unsigned BYTE_W     = 8;
   localparam int unsigned CNT_W      = 16;
   localparam int unsigned FIFO_DEPTH = 4;

   // ****************************************
   // Synchroniser vector layout
   // ****************************************
   localparam int unsigned SY_DATA = 0;
   localparam int unsigned SY_CONFIG_CLOCK = 8;
   localparam int unsigned SY_PROG = 9;
   localparam int unsigned SY_INIT = 10;
   localparam int unsigned SY_CS   = 11;
   localparam int unsigned SY_MHI  = 12;
   localparam int unsigned SY_W    = 13;

   // ****************************************
   // Timing counts
   // ****************************************
   localparam logic [CNT_W-1:0] CLR_PASS_CYC   = 16'h0040;
   localparam logic [CNT_W-1:0] STARTUP_EDGES  = 16'h0004;
   localparam logic [CNT_W-1:0] IO_ACTIVE_EDGE = 16'h0002;
   localparam logic [CNT_W-1:0] CFG_BYTES_DEF  = 16'hbd61;
   localparam logic [CNT_W-1:0] CNT_ONE        = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO       = 16'h0000;

   // ****************************************
   // Phases
   // ****************************************
   typedef enum logic [2:0] {
      ST_CLEAR      = 3'b000,
      ST_CLEAR_LAST = 3'b001,
      ST_INIT_WAIT  = 3'b010,
      ST_LOAD       = 3'b011,
      ST_STARTUP    = 3'b100,
      ST_USER       = 3'b101,
      ST_NO_MODE    = 3'b110
   } bwc_state_t;

   typedef struct packed {
      bwc_state_t        st;
      logic [SY_W-1:0]   s1;
      logic [SY_W-1:0]   s2;
      logic              config_clock_p;
      logic [BYTE_W-1:0] data_p;
      logic [CNT_W-1:0]  cnt;
      logic [CNT_W-1:0]  n_in;
      logic [CNT_W-1:0]  n_wr;
      logic              push;
      logic [BYTE_W-1:0] byte_v;
      logic              chain;
      logic              overrun;
      logic              io_act;
   } bwc_regs_t;

endpackage

//--- bwc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module bwc_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 4
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Fill side
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // Drain side
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);
   localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
   localparam int unsigned CW = $clog2(D + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(D);
   localparam logic [AW-1:0] LAST_PTR = AW'(D - 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [CW-1:0]       cnt;
   } bwc_fifo_regs_t;

   bwc_fifo_regs_t q;
   bwc_fifo_regs_t d;
   logic           wr;
   logic           rd;

   assign in_ready_o  = (q.cnt != FULL_CNT);
   assign out_valid_o = (q.cnt != '0);
   assign out_data_o  = q.mem[q.rp];
   assign wr          = in_valid_i && in_ready_o;
   assign rd          = out_valid_o && out_ready_i;

   always_comb begin
      d = q;
      if (wr) begin
         d.mem[q.wp] = in_data_i;
         d.wp = (q.wp == LAST_PTR) ? '0 : AW'(q.wp + 1'b1);
      end
      if (rd) begin
         d.rp = (q.rp == LAST_PTR) ? '0 : AW'(q.rp + 1'b1);
      end
      if (wr && !rd) begin
         d.cnt = CW'(q.cnt + 1'b1);
      end else if (rd && !wr) begin
         d.cnt = CW'(q.cnt - 1'b1);
      end
      if (rst_i) begin
         d = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      q <= d;
   end
endmodule // bwc_fifo
`default_nettype wire

//--- bwc_config_port.sv
// Contract
// - One byte on the eight data pins per config clock cycle.
// - After power-on reset, memory clearing starts by itself.
// - Program low pulse restarts clearing from any phase except ST_CLEAR, where the current pass runs on.
// - While program is low, clearing passes repeat; program sampled each pass end.
// - Program high after a pass: one more pass, then init released.
// - Init line released only once memory is fully cleared.
// - After init rises, high-mode pin sampled; byte-wide loader enabled only when it is low, otherwise no loader runs.
// - Init held low externally postpones configuration.
// - Byte-wide mode selected by low high-mode pin; low mode pin ignored.
// - Data captured on rising edge of the config clock.
// - Chain-enable output lets the next device load.
// - Chain select high required to accept bytes.
// - Open-drain done released high when configuration completes.
// - High/low status outputs hold during configuration until I/Os active.
// - Phases in order: clearing, initialization, loading, start-up.
// - Bytes accepted until CFG_BYTES received; once memory full, done rises and start-up begins.
// - Start-up spans four config clock edges supplied by the master.
// - Chain enable low when init rises, high once memory is full.
`timescale 1ns/1ps
`default_nettype none
module bwc_config_port
   import bwc_pkg::*;
#(
   parameter logic [CNT_W-1:0] CFG_BYTES = CFG_BYTES_DEF
) (
   // Clock and reset
   input  wire logic              mclk_i,
   input  wire logic              sys_rst_i,
   // Configuration pins
   input  wire logic              config_clock_i,
   input  wire logic [BYTE_W-1:0] config_byte_in_i,
   input  wire logic              program_n_i,
   input  wire logic              chain_select_in_i,
   input  wire logic              mode_select_hi_i,
   // Open-drain init line
   input  wire logic              init_n_i,
   output logic                   init_n_o,
   output logic                   init_n_oe_n_o,
   // Open-drain done line
   output logic                   done_o,
   output logic                   done_oe_n_o,
   // Status outputs
   output logic                   chain_enable_o,
   output logic                   high_during_cfg_o,
   output logic                   low_during_cfg_o,
   output logic                   overrun_o,
   // Configuration memory write port
   output logic                   mem_wr_valid_o,
   input  wire logic              mem_wr_ready_i,
   output logic [BYTE_W-1:0]      mem_wr_data_o
);

   // ****************************************
   // State and datapath
   // ****************************************
   bwc_regs_t         q;
   bwc_regs_t         d;
   logic              rise;
   logic              mem_full;
   logic              in_done;
   logic              fifo_ready;
   logic              pop;
   logic              clearing;
   logic              fifo_flush;

   assign rise     = q.s2[SY_CONFIG_CLOCK] && !q.config_clock_p;
   assign mem_full = (q.n_wr == CFG_BYTES);
   assign in_done  = (q.n_in == CFG_BYTES);
   assign pop      = mem_wr_valid_o && mem_wr_ready_i;
   assign clearing = (q.st == ST_CLEAR) || (q.st == ST_CLEAR_LAST);
   assign fifo_flush = sys_rst_i || clearing;

   bwc_fifo #(
      .W (BYTE_W),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (mclk_i),
      .rst_i       (fifo_flush),
      .in_valid_i  (q.push),
      .in_ready_o  (fifo_ready),
      .in_data_i   (q.byte_v),
      .out_valid_o (mem_wr_valid_o),
      .out_ready_i (mem_wr_ready_i),
      .out_data_o  (mem_wr_data_o)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      d        = q;
      d.s1     = {mode_select_hi_i, chain_select_in_i, init_n_i,
                  program_n_i, config_clock_i, config_byte_in_i};
      d.s2     = q.s1;
      d.config_clock_p = q.s2[SY_CONFIG_CLOCK];
      d.data_p = q.s2[SY_DATA +: BYTE_W];
      d.push   = 1'b0;
      if (pop) begin
         d.n_wr = CNT_W'(q.n_wr + CNT_ONE);
      end
      case (q.st)
         ST_CLEAR: begin
            d.cnt = CNT_W'(q.cnt + CNT_ONE);
            if (q.cnt == CNT_W'(CLR_PASS_CYC - CNT_ONE)) begin
               d.cnt = CNT_ZERO;
               if (q.s2[SY_PROG]) begin
                  d.st = ST_CLEAR_LAST;
               end
            end
         end
         ST_CLEAR_LAST: begin
            d.cnt = CNT_W'(q.cnt + CNT_ONE);
            if (q.cnt == CNT_W'(CLR_PASS_CYC - CNT_ONE)) begin
               d.cnt = CNT_ZERO;
               d.st  = ST_INIT_WAIT;
            end
         end
         ST_INIT_WAIT: begin
            if (q.s2[SY_INIT]) begin
               if (!q.s2[SY_MHI]) begin
                  d.st   = ST_LOAD;
                  d.n_in = CNT_ZERO;
                  d.n_wr = CNT_ZERO;
                  d.chain = 1'b0;
               end else begin
                  d.st = ST_NO_MODE;
               end
            end
         end
         ST_LOAD: begin
            if (rise && q.s2[SY_CS] && !in_done) begin
               if (fifo_ready) begin
                  d.push   = 1'b1;
                  d.byte_v = q.data_p;
                  d.n_in   = CNT_W'(q.n_in + CNT_ONE);
               end else begin
                  d.overrun = 1'b1;
               end
            end
            if (mem_full) begin
               d.st    = ST_STARTUP;
               d.cnt   = CNT_ZERO;
               d.chain = 1'b1;
            end
         end
         ST_STARTUP: begin
            if (rise) begin
               d.cnt = CNT_W'(q.cnt + CNT_ONE);
               if (q.cnt == CNT_W'(IO_ACTIVE_EDGE - CNT_ONE)) begin
                  d.io_act = 1'b1;
               end
               if (q.cnt == CNT_W'(STARTUP_EDGES - CNT_ONE)) begin
                  d.st = ST_USER;
               end
            end
         end
         ST_USER: begin
            d.st = ST_USER;
         end
         ST_NO_MODE: begin
            d.st = ST_NO_MODE;
         end
         default: begin
            d.st = ST_CLEAR;
         end
      endcase
      if (!q.s2[SY_PROG] && q.st != ST_CLEAR) begin
         d.st      = ST_CLEAR;
         d.cnt     = CNT_ZERO;
         d.chain   = 1'b0;
         d.io_act  = 1'b0;
         d.overrun = 1'b0;
         d.push    = 1'b0;
      end
      if (sys_rst_i) begin
         d    = '0;
         d.st = ST_CLEAR;
      end
   end

   always_ff @(posedge mclk_i) begin
      q <= d;
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign init_n_o = 1'b0;
   assign init_n_oe_n_o = !clearing;
   assign done_o        = 1'b0;
   assign done_oe_n_o = (q.st == ST_STARTUP) || (q.st == ST_USER);
   assign chain_enable_o = q.chain;
   assign high_during_cfg_o = !q.io_act;
   assign low_during_cfg_o  = q.io_act;
   assign overrun_o         = q.overrun;

   // ****************************************
   // Assertions
   // ****************************************
   property p_init_held_clear;
      @(posedge mclk_i) disable iff (sys_rst_i)
      clearing |-> !init_n_oe_n_o && !init_n_o;
   endproperty
   a_init_held_clear: assert property (p_init_held_clear)
      else $error("init released during clearing");

   property p_pass_repeat;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (q.st == ST_CLEAR && q.cnt == CNT_W'(CLR_PASS_CYC - CNT_ONE) && !q.s2[SY_PROG])
         |=> q.st == ST_CLEAR && q.cnt == CNT_ZERO;
   endproperty
   a_pass_repeat: assert property (p_pass_repeat)
      else $error("clearing pass not repeated");

   property p_last_pass;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (q.st == ST_CLEAR_LAST && q.cnt != CNT_W'(CLR_PASS_CYC - CNT_ONE) && q.s2[SY_PROG])
         |=> q.st == ST_CLEAR_LAST && !init_n_oe_n_o;
   endproperty
   a_last_pass: assert property (p_last_pass)
      else $error("last pass cut short");

   property p_init_low_blocks;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (q.st == ST_INIT_WAIT && !q.s2[SY_INIT] && q.s2[SY_PROG]) |=> q.st == ST_INIT_WAIT;
   endproperty
   a_init_low_blocks: assert property (p_init_low_blocks)
      else $error("left init wait while init low");

   property p_mode_pick;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (q.st == ST_INIT_WAIT && q.s2[SY_INIT] && q.s2[SY_PROG])
         |=> q.st == ($past(q.s2[SY_MHI]) ? ST_NO_MODE : ST_LOAD);
   endproperty
   a_mode_pick: assert property (p_mode_pick)
      else $error("wrong mode decision");

   property p_capture;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (q.st == ST_LOAD && rise && q.s2[SY_CS] && !in_done && fifo_ready && q.s2[SY_PROG])
         |=> q.push && q.byte_v == $past(q.data_p);
   endproperty
   a_capture: assert property (p_capture)
      else $error("byte not captured on edge");

   property p_ignore;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (!(q.st == ST_LOAD) || !q.s2[SY_CS] || in_done || !rise) |=> !q.push;
   endproperty
   a_ignore: assert property (p_ignore)
      else $error("byte accepted while ineligible");

   property p_chain_load;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (q.st == ST_LOAD) |-> !chain_enable_o && !done_oe_n_o && high_during_cfg_o && !low_during_cfg_o;
   endproperty
   a_chain_load: assert property (p_chain_load)
      else $error("status wrong during loading");

   property p_full_done;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (q.st == ST_LOAD && mem_full && q.s2[SY_PROG]) |=> done_oe_n_o && chain_enable_o;
   endproperty
   a_full_done: assert property (p_full_done)
      else $error("done or chain not raised at full");

   property p_startup_end;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (q.st == ST_STARTUP && rise && q.cnt == CNT_W'(STARTUP_EDGES - CNT_ONE) && q.s2[SY_PROG])
         |=> q.st == ST_USER && low_during_cfg_o;
   endproperty
   a_startup_end: assert property (p_startup_end)
      else $error("start-up did not end after four edges");

   property p_prog_restart;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (!q.s2[SY_PROG] && q.st != ST_CLEAR) |=> q.st == ST_CLEAR ##1 !init_n_oe_n_o;
   endproperty
   a_prog_restart: assert property (p_prog_restart)
      else $error("program pulse did not restart clearing");

   property p_clear_to_init;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (q.st == ST_CLEAR_LAST && q.cnt == CNT_W'(CLR_PASS_CYC - CNT_ONE) && q.s2[SY_PROG])
         |=> q.st == ST_INIT_WAIT && init_n_oe_n_o;
   endproperty
   a_clear_to_init: assert property (p_clear_to_init)
      else $error("init not released after last pass");

   property p_io_active;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (q.st == ST_STARTUP && rise && q.cnt == CNT_W'(IO_ACTIVE_EDGE - CNT_ONE) && q.s2[SY_PROG])
         |=> !high_during_cfg_o && low_during_cfg_o;
   endproperty
   a_io_active: assert property (p_io_active)
      else $error("status outputs not switched at second edge");

   property p_overrun;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (q.st == ST_LOAD && rise && q.s2[SY_CS] && !in_done && !fifo_ready && q.s2[SY_PROG])
         |=> overrun_o && !q.push;
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("byte into full buffer not flagged");

   property p_user_status;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (q.st == ST_USER) |-> done_oe_n_o && !high_during_cfg_o && low_during_cfg_o;
   endproperty
   a_user_status: assert property (p_user_status)
      else $error("status wrong in user phase");

   property p_flush;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (clearing && q.cnt != CNT_ZERO) |-> !mem_wr_valid_o;
   endproperty
   a_flush: assert property (p_flush)
      else $error("stale byte offered during clearing");

   c_load:    cover property (@(posedge mclk_i) disable iff (sys_rst_i) q.st == ST_LOAD ##1 q.push);
   c_startup: cover property (@(posedge mclk_i) disable iff (sys_rst_i) q.st == ST_STARTUP ##1 q.st == ST_USER);
   c_reprog:  cover property (@(posedge mclk_i) disable iff (sys_rst_i) q.st == ST_USER ##1 q.st == ST_CLEAR);
   c_stall:   cover property (@(posedge mclk_i) disable iff (sys_rst_i) q.overrun);
   c_no_mode: cover property (@(posedge mclk_i) disable iff (sys_rst_i) q.st == ST_NO_MODE);

endmodule // bwc_config_port
`default_nettype wire

//--- bwc_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module bwc_master_model
   import bwc_pkg::*;
(
   // Clock
   input  wire logic         mclk_i,
   // Configuration pins
   output logic              config_clock_o,
   output logic [BYTE_W-1:0] config_byte_o,
   output logic              program_n_o,
   output logic              init_hold_n_o
);
   // ****************************************
   // Idle levels
   // ****************************************
   // init held low at power-up
   initial begin
      config_clock_o = 1'b0;
      config_byte_o  = 8'h00;
      program_n_o    = 1'b1;
      init_hold_n_o  = 1'b0;
   end

   // ****************************************
   // Transfers
   // ****************************************
   // one byte per 8-cycle clock
   task automatic send_byte(input logic [BYTE_W-1:0] b);
      config_byte_o <= b;
      repeat (4) @(posedge mclk_i);
      config_clock_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
      config_clock_o <= 1'b0;
   endtask

   task automatic pulse_program(input int n);
      @(posedge mclk_i) program_n_o <= 1'b0;
      repeat (n) @(posedge mclk_i);
      program_n_o <= 1'b1;
   endtask

   task automatic release_init(input int n);
      @(posedge mclk_i) init_hold_n_o <= 1'b1;
      repeat (n) @(posedge mclk_i);
   endtask
endmodule // bwc_master_model
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import bwc_pkg::*;
;
   // ****************************************
   // Signals
   // ****************************************
   localparam logic [CNT_W-1:0] N_BYTES   = 16'h0006;
   localparam int               INIT_WAIT = 130;
   logic              mclk = 1'b0;
   logic              sys_rst = 1'b1;
   logic              config_clock, prog_n, init_hold_n, init_wire, init_n_o, init_oe_n;
   logic [BYTE_W-1:0] cbyte, wr_data;
   logic              cs = 1'b1;
   logic              mode_hi = 1'b0;
   logic              done_o, done_oe_n, chain_en, high_during_cfg, low_during_cfg, overrun, wr_valid;
   logic              wr_ready = 1'b0;
   logic              rdy_en = 1'b0;
   int                seed = 40097;
   int                rnd, n;
   int                n_errors = 0;
   int                comparisons = 0;
   logic [BYTE_W-1:0] exp_q[$];

   always #20 mclk = ~mclk;
   assign init_wire = (init_oe_n ? 1'b1 : init_n_o) & init_hold_n;

   bwc_master_model u_master (.mclk_i(mclk), .config_clock_o(config_clock), .config_byte_o(cbyte),
      .program_n_o(prog_n), .init_hold_n_o(init_hold_n));

   bwc_config_port #(.CFG_BYTES(N_BYTES)) DUT (
      .mclk_i(mclk), .sys_rst_i(sys_rst), .config_clock_i(config_clock), .config_byte_in_i(cbyte),
      .program_n_i(prog_n), .chain_select_in_i(cs), .mode_select_hi_i(mode_hi),
      .init_n_i(init_wire), .init_n_o(init_n_o), .init_n_oe_n_o(init_oe_n),
      .done_o(done_o), .done_oe_n_o(done_oe_n), .chain_enable_o(chain_en),
      .high_during_cfg_o(high_during_cfg), .low_during_cfg_o(low_during_cfg), .overrun_o(overrun),
      .mem_wr_valid_o(wr_valid), .mem_wr_ready_i(wr_ready), .mem_wr_data_o(wr_data));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input string what, input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("Errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic wait_high(input bit on_done, output int cnt);
      cnt = 0;
      while ((on_done ? done_oe_n : init_oe_n) !== 1'b1 && cnt < 3000) begin
         @(posedge mclk);
         cnt++;
      end
      check("wait bound", 16'(cnt < 3000), 16'h0001);
   endtask

   task automatic load(input int cnt, input bit keep);
      logic [BYTE_W-1:0] b;
      for (int i = 0; i < cnt; i++) begin
         b = 8'($random(seed));
         if (keep) exp_q.push_back(b);
         u_master.send_byte(b);
      end
   endtask

   task automatic restart(input logic mode);
      mode_hi <= mode;
      u_master.pulse_program(10);
      wait_high(1'b0, n);
      repeat (INIT_WAIT) @(posedge mclk);
   endtask

   // ****************************************
   // Memory sink and scoreboard
   // ****************************************
   always @(posedge mclk) begin
      rnd = $random(seed);
      wr_ready <= rdy_en & rnd[0];
      if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
         if (exp_q.size() == 0) check("unexpected write", {8'h00, wr_data}, 16'hffff);
         else check("memory byte", {8'h00, wr_data}, {8'h00, exp_q.pop_front()});
      end
   end

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
      check("init oe_n in reset", 16'(init_oe_n), 16'h0000);
      check("done oe_n in reset", 16'(done_oe_n), 16'h0000);
      check("chain in reset", 16'(chain_en), 16'h0000);
      check("status in reset", 16'({high_during_cfg, low_during_cfg}), 16'h0002);
      check("open-drain data", 16'({init_n_o, done_o}), 16'h0000);
      wait_high(1'b0, n);
      check("power-on clear span", 16'(n >= 128), 16'h0001);
      u_master.send_byte(8'h5a);
      check("chain after init", 16'(chain_en), 16'h0000);
      u_master.release_init(INIT_WAIT);
      check("chain in load", 16'(chain_en), 16'h0000);
      cs <= 1'b0;
      u_master.send_byte(8'ha5);
      cs <= 1'b1;
      rdy_en <= 1'b1;
      load(N_BYTES, 1'b1);
      wait_high(1'b1, n);
      repeat (2) @(posedge mclk);
      check("chain when full", 16'(chain_en), 16'h0001);
      check("bytes left", 16'(exp_q.size()), 16'h0000);
      check("status at done", 16'({high_during_cfg, low_during_cfg}), 16'h0002);
      load(1, 1'b0);
      check("status after edge 1", 16'({high_during_cfg, low_during_cfg}), 16'h0002);
      load(1, 1'b0);
      repeat (4) @(posedge mclk);
      check("status after edge 2", 16'({high_during_cfg, low_during_cfg}), 16'h0001);
      load(2, 1'b0);
      check("done in user", 16'({done_oe_n, low_during_cfg}), 16'h0003);
      u_master.pulse_program(200);
      check("init held in clear", 16'(init_oe_n), 16'h0000);
      check("outputs after program", 16'({high_during_cfg, low_during_cfg, chain_en, done_oe_n}), 16'h0008);
      wait_high(1'b0, n);
      check("last pass span", 16'(n >= 64 && n <= 140), 16'h0001);
      restart(1'b1);
      load(2, 1'b0);
      check("other mode idle", 16'({done_oe_n, high_during_cfg}), 16'h0001);
      rdy_en <= 1'b0;
      restart(1'b0);
      load(4, 1'b1);
      load(1, 1'b0);
      check("overrun set", 16'(overrun), 16'h0001);
      rdy_en <= 1'b1;
      repeat (40) @(posedge mclk);
      check("fifo drained", 16'(exp_q.size()), 16'h0000);
      u_master.pulse_program(10);
      repeat (4) @(posedge mclk);
      check("overrun cleared", 16'(overrun), 16'h0000);
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge mclk);
      n_errors++;
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
